// ==== design/rsh_consts.svh ====
// Purpose: offsets, fields, reset values and timing counts of the selector
// Assumes: 50 MHz sampling clock (PLL feedback), byte-wide register map
// Notes: definitions only
`ifndef RSH_CONSTS_SVH
`define RSH_CONSTS_SVH

`define RSH_CLK_MHZ 50
`define RSH_OFS_CAL_CTRL 8'h0E
`define RSH_OFS_BAND_OVR 8'h10
`define RSH_OFS_SW_MODE 8'h29
`define RSH_CAL_GO_BIT 7
`define RSH_CAL_EN_BIT 2
`define RSH_BAND_EN_BIT 0
`define RSH_BAND_MSB 7
`define RSH_BAND_LSB 1
`define RSH_MODE_MSB 7
`define RSH_MODE_LSB 6
`define RSH_CAL_CTRL_RST 8'h00
`define RSH_BAND_OVR_RST 8'h00
`define RSH_SW_MODE_RST 8'h00
`define RSH_FB_DIV_MIN 20'h0_0020
`define RSH_FB_DIV_LOW_BW 20'h0_4000
`define RSH_DET_WINDOW_NS 2000
`define RSH_DET_WINDOW_CYC ((`RSH_DET_WINDOW_NS * `RSH_CLK_MHZ) / 1000)
`define RSH_CAL_SETTLE_NS 1000
`define RSH_CAL_SETTLE_CYC ((`RSH_CAL_SETTLE_NS * `RSH_CLK_MHZ + 999) / 1000)

`endif

// ==== design/rsh_pkg.sv ====
// Purpose: shared types of the reference selector
// Assumes: nothing beyond the constants header
// Notes: types only, numbers live in rsh_consts.svh
package rsh_pkg;
    // Switchover mode field encoding
    typedef enum logic [1:0] {
        RSH_MODE_REVERT = 2'b00,
        RSH_MODE_NONREV = 2'b01,
        RSH_MODE_MAN_PRI = 2'b10,
        RSH_MODE_MAN_SEC = 2'b11
    } rsh_mode_t;

    // Input routed to the PLL
    typedef enum logic [1:0] {
        RSH_SEL_NONE = 2'b00,
        RSH_SEL_PRI = 2'b01,
        RSH_SEL_SEC = 2'b10,
        RSH_SEL_CRYSTAL_INPUT = 2'b11
    } rsh_sel_t;

    // Calibration sequencer states
    typedef enum logic [1:0] {
        RSH_CAL_IDLE = 2'b00,
        RSH_CAL_SETTLE = 2'b01,
        RSH_CAL_DECIDE = 2'b10,
        RSH_CAL_GAIN = 2'b11
    } rsh_cal_state_t;
endpackage

// ==== design/rsh_cal_if.sv ====
// Purpose: handshake between selector top and calibration sequencer
// Assumes: one clock domain
// Notes: start is a one-cycle pulse, busy a level
`timescale 1ns/1ps
interface rsh_cal_if #(parameter int BAND_W = 7);
    logic start;
    logic busy;
    logic [BAND_W-1:0] band;

    modport ctrl (output start, input busy, input band);
    modport seq (input start, output busy, output band);
endinterface

// ==== design/rsh_presence_det.sv ====
// Purpose: signal presence detector for one clock input
// Assumes: sampled by the PLL feedback clock, which always runs
// Notes: present while an edge was seen within the last window
`timescale 1ns/1ps
module rsh_presence_det #(
    parameter int WINDOW = 100,
    parameter int CNT_W = 16
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic sig_in,
    output logic present_out
);
    logic sync1_r;
    logic sync2_r;
    logic prev_r;
    logic [CNT_W-1:0] quiet_r;

    // Two-stage synchroniser, first stage feeds only the second
    always_ff @(posedge clk_in) begin
        sync1_r <= sig_in;
        sync2_r <= sync1_r;
        prev_r <= sync2_r;
    end

    // Quiet-time counter restarts on every edge of the input
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            quiet_r <= '0;
            present_out <= 1'b0;
        end else if (sync2_r != prev_r) begin
            quiet_r <= '0;
            present_out <= 1'b1;
        end else if (quiet_r >= CNT_W'(WINDOW)) begin
            present_out <= 1'b0;
        end else begin
            quiet_r <= quiet_r + CNT_W'(1);
        end
    end
endmodule

// ==== design/rsh_vco_cal.sv ====
// Purpose: VCO band search and gain trim sequencer
// Assumes: band comparator from the analog VCO, asynchronous to clk_in
// Notes: successive approximation, MSB first, one settle per step
`timescale 1ns/1ps
`include "rsh_consts.svh"
module rsh_vco_cal
    import rsh_pkg::*;
#(
    parameter int BAND_W = 7,
    parameter int SETTLE = `RSH_CAL_SETTLE_CYC
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic vco_above_in,
    rsh_cal_if.seq cal
);
    rsh_cal_state_t state_r;
    logic above1_r;
    logic above2_r;
    logic [15:0] wait_r;
    logic [BAND_W-1:0] trial_r;
    logic [BAND_W-1:0] bit_r;

    // Comparator crosses in from the analog side
    always_ff @(posedge clk_in) begin
        above1_r <= vco_above_in;
        above2_r <= above1_r;
    end

    // Search: keep a trial bit when the VCO still runs low
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state_r <= RSH_CAL_IDLE;
            wait_r <= '0;
            trial_r <= '0;
            bit_r <= '0;
            cal.band <= '0;
            cal.busy <= 1'b0;
        end else begin
            unique case (state_r)
                RSH_CAL_IDLE: begin
                    if (cal.start) begin
                        bit_r <= {1'b1, {(BAND_W-1){1'b0}}};
                        trial_r <= {1'b1, {(BAND_W-1){1'b0}}};
                        cal.band <= {1'b1, {(BAND_W-1){1'b0}}};
                        wait_r <= 16'(SETTLE);
                        cal.busy <= 1'b1;
                        state_r <= RSH_CAL_SETTLE;
                    end
                end
                RSH_CAL_SETTLE: begin
                    if (wait_r <= 16'h0001) begin
                        state_r <= RSH_CAL_DECIDE;
                    end else begin
                        wait_r <= wait_r - 16'h0001;
                    end
                end
                RSH_CAL_DECIDE: begin
                    // Drop the bit if the band overshoots
                    if (above2_r) begin
                        trial_r <= (trial_r & ~bit_r) | (bit_r >> 1);
                        cal.band <= (trial_r & ~bit_r) | (bit_r >> 1);
                    end else begin
                        trial_r <= trial_r | (bit_r >> 1);
                        cal.band <= trial_r | (bit_r >> 1);
                    end
                    bit_r <= bit_r >> 1;
                    wait_r <= 16'(SETTLE);
                    state_r <= (bit_r == BAND_W'(1)) ? RSH_CAL_GAIN
                                                     : RSH_CAL_SETTLE;
                    if (bit_r == BAND_W'(1)) begin
                        cal.band <= above2_r ? (trial_r & ~bit_r) : trial_r;
                    end
                end
                RSH_CAL_GAIN: begin
                    // Gain trim settles over one more window
                    if (wait_r <= 16'h0001) begin
                        cal.busy <= 1'b0;
                        state_r <= RSH_CAL_IDLE;
                    end else begin
                        wait_r <= wait_r - 16'h0001;
                    end
                end
            endcase
        end
    end
endmodule

// ==== design/rsh_switchover.sv ====
// Purpose: reference switchover, holdover and PLL control logic
// Assumes: clk_in is the PLL feedback clock, always running
// Notes: register port is the serial controller's internal write/read side
`timescale 1ns/1ps
`include "rsh_consts.svh"

module rsh_switchover
    import rsh_pkg::*;
#(
    parameter int BAND_W = 7,
    parameter int DIV_W = 20,
    parameter int DET_WINDOW = `RSH_DET_WINDOW_CYC,
    parameter int CAL_SETTLE = `RSH_CAL_SETTLE_CYC
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic primary_reference_input_in,
    input wire logic secondary_reference_input_in,
    input wire logic crystal_input_in,
    input wire logic force_secondary_pin_in,
    input wire logic [3:0] freq_sel_a_in,
    input wire logic [5:0] freq_sel_y_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [DIV_W-1:0] fb_div_in,
    input wire logic pri_prescale_in,
    input wire logic pri_double_in,
    input wire logic sec_prescale_in,
    input wire logic sec_double_in,
    input wire logic vco_above_in,
    output logic [7:0] reg_rdata_out,
    output logic [1:0] ref_select_out,
    output logic holdover_out,
    output logic [2:0] present_out,
    output logic [BAND_W-1:0] vco_band_out,
    output logic cal_busy_out,
    output logic drivers_static_out,
    output logic [DIV_W-1:0] fb_div_out,
    output logic low_bw_filter_out,
    output logic [1:0] pri_path_out,
    output logic [1:0] sec_path_out
);
    rsh_cal_if #(.BAND_W(BAND_W)) cal_bus ();

    logic pri_ok;
    logic sec_ok;
    logic crystal_input_ok;
    logic force1_r;
    logic force2_r;
    logic [9:0] pins1_r;
    logic [9:0] pins2_r;
    logic spi_mode;
    logic wr_ok;
    logic [7:0] cal_ctrl_r;
    logic [7:0] band_ovr_r;
    logic [7:0] sw_mode_r;
    logic cal_req_r;
    logic boot_r;
    logic start_r;
    rsh_mode_t mode;
    rsh_sel_t sel_r;
    rsh_sel_t sel_nxt;
    logic [DIV_W-1:0] div_nxt;

    // One detector per input, all on the feedback clock
    rsh_presence_det #(.WINDOW(DET_WINDOW), .CNT_W(16)) u_det_pri (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .sig_in(primary_reference_input_in),
        .present_out(pri_ok)
    );
    rsh_presence_det #(.WINDOW(DET_WINDOW), .CNT_W(16)) u_det_sec (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .sig_in(secondary_reference_input_in),
        .present_out(sec_ok)
    );
    rsh_presence_det #(.WINDOW(DET_WINDOW), .CNT_W(16)) u_det_crystal_input (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .sig_in(crystal_input_in),
        .present_out(crystal_input_ok)
    );

    // Band search sequencer, 7-bit code covers all 128 bands
    rsh_vco_cal #(.BAND_W(BAND_W), .SETTLE(CAL_SETTLE)) u_cal (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .vco_above_in(vco_above_in),
        .cal(cal_bus.seq)
    );

    // Pins are asynchronous: two flops before use
    always_ff @(posedge clk_in) begin
        force1_r <= force_secondary_pin_in;
        force2_r <= force1_r;
        pins1_r <= {freq_sel_a_in, freq_sel_y_in};
        pins2_r <= pins1_r;
    end

    // Serial mode when either the A or the Y selection pins are all zero
    assign spi_mode = (pins2_r[9:6] == 4'h0) || (pins2_r[5:0] == 6'h00);
    assign wr_ok = reg_wr_in && spi_mode;
    assign mode = rsh_mode_t'(sw_mode_r[`RSH_MODE_MSB:`RSH_MODE_LSB]);

    // Register map writes; mode resets to revertive
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            cal_ctrl_r <= `RSH_CAL_CTRL_RST;
            band_ovr_r <= `RSH_BAND_OVR_RST;
            sw_mode_r <= `RSH_SW_MODE_RST;
        end else if (wr_ok) begin
            if (reg_addr_in == `RSH_OFS_CAL_CTRL) begin
                cal_ctrl_r <= reg_wdata_in & ~(8'h01 << `RSH_CAL_GO_BIT);
            end
            if (reg_addr_in == `RSH_OFS_BAND_OVR) begin
                band_ovr_r <= reg_wdata_in & 8'hFE;
            end
            if (reg_addr_in == `RSH_OFS_SW_MODE) begin
                sw_mode_r <= reg_wdata_in;
            end
        end
    end

    // Calibrate request: needs the enable, cleared when launched
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            cal_req_r <= 1'b0;
        end else if (wr_ok && reg_addr_in == `RSH_OFS_CAL_CTRL &&
                     reg_wdata_in[`RSH_CAL_GO_BIT] &&
                     reg_wdata_in[`RSH_CAL_EN_BIT]) begin
            cal_req_r <= 1'b1;
        end else if (start_r) begin
            cal_req_r <= 1'b0;
        end
    end

    // Start pulse; boot flag launches one run after reset
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            boot_r <= 1'b1;
            start_r <= 1'b0;
        end else begin
            start_r <= (boot_r || cal_req_r) && !start_r &&
                       !cal_bus.busy;
            if (start_r) begin
                boot_r <= 1'b0;
            end
        end
    end
    assign cal_bus.start = start_r;

    // Register readback; calibrate bit reads back as pending or running
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= 8'h00;
        end else begin
            unique case (reg_addr_in)
                `RSH_OFS_CAL_CTRL: reg_rdata_out <= cal_ctrl_r |
                    (8'((cal_req_r || cal_bus.busy)) << `RSH_CAL_GO_BIT);
                `RSH_OFS_BAND_OVR: reg_rdata_out <= band_ovr_r;
                `RSH_OFS_SW_MODE: reg_rdata_out <= sw_mode_r;
                default: reg_rdata_out <= 8'h00;
            endcase
        end
    end

    // Selection decision from detector outputs each cycle
    always_comb begin
        sel_nxt = RSH_SEL_NONE; // Nothing present: wait
        unique case (mode)
            RSH_MODE_MAN_PRI: begin
                // No holdover in manual modes
                if (force2_r && sec_ok) begin
                    sel_nxt = RSH_SEL_SEC;
                end else if (pri_ok) begin
                    sel_nxt = RSH_SEL_PRI;
                end
            end
            RSH_MODE_MAN_SEC: begin
                if (sec_ok) begin
                    sel_nxt = RSH_SEL_SEC;
                end
            end
            RSH_MODE_NONREV: begin
                if (sec_ok && (force2_r || sel_r == RSH_SEL_SEC)) begin
                    sel_nxt = RSH_SEL_SEC;
                end else if (pri_ok) begin
                    sel_nxt = RSH_SEL_PRI;
                end else if (sec_ok) begin
                    sel_nxt = RSH_SEL_SEC;
                end else if (crystal_input_ok) begin
                    sel_nxt = RSH_SEL_CRYSTAL_INPUT;
                end
            end
            RSH_MODE_REVERT: begin
                if (force2_r && sec_ok) begin
                    sel_nxt = RSH_SEL_SEC;
                end else if (pri_ok) begin
                    sel_nxt = RSH_SEL_PRI;
                end else if (sec_ok) begin
                    sel_nxt = RSH_SEL_SEC;
                end else if (crystal_input_ok) begin
                    sel_nxt = RSH_SEL_CRYSTAL_INPUT;
                end
            end
        endcase
    end

    // Mux select comes from one flop so it never glitches
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            sel_r <= RSH_SEL_NONE;
            ref_select_out <= RSH_SEL_NONE;
            holdover_out <= 1'b0;
            present_out <= 3'h0;
        end else begin
            sel_r <= sel_nxt;
            ref_select_out <= sel_nxt;
            holdover_out <= (sel_nxt == RSH_SEL_CRYSTAL_INPUT);
            present_out <= {crystal_input_ok, sec_ok, pri_ok};
        end
    end

    // Band source and static drivers while calibrating
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            vco_band_out <= '0;
            cal_busy_out <= 1'b0;
            drivers_static_out <= 1'b1;
        end else begin
            vco_band_out <= cal_ctrl_r[`RSH_BAND_EN_BIT] ?
                band_ovr_r[`RSH_BAND_MSB:`RSH_BAND_LSB] :
                cal_bus.band;
            cal_busy_out <= cal_bus.busy;
            drivers_static_out <= cal_bus.busy || boot_r ||
                                  start_r;
        end
    end

    // Divider clamped to its floor; sets VCO = phase_detector_frequency * N
    assign div_nxt = (fb_div_in < DIV_W'(`RSH_FB_DIV_MIN)) ?
                     DIV_W'(`RSH_FB_DIV_MIN) : fb_div_in;

    // Divider, filter choice and reference path settings
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            fb_div_out <= DIV_W'(`RSH_FB_DIV_MIN);
            low_bw_filter_out <= 1'b0;
            pri_path_out <= 2'b00;
            sec_path_out <= 2'b00;
        end else begin
            fb_div_out <= div_nxt;
            low_bw_filter_out <=
                (div_nxt >= DIV_W'(`RSH_FB_DIV_LOW_BW));
            // Bit 1: divide-by-five ahead of bit 0: doubler
            pri_path_out <= {pri_prescale_in, pri_double_in};
            sec_path_out <= {sec_prescale_in, sec_double_in};
        end
    end
endmodule

// ==== test/rsh_ref_model.sv ====
// Purpose: reference and crystal clock sources feeding the selector
// Assumes: the bench switches each source on or off at will
// Notes: a stopped source rests low, the way an idle clock line does
`timescale 1ns/1ps
module rsh_ref_model (
    input wire logic [2:0] on_in,
    output logic pri_out,
    output logic sec_out,
    output logic crystal_input_out
);
    // Start every line low
    initial begin
        pri_out = 1'b0;
        sec_out = 1'b0;
        crystal_input_out = 1'b0;
    end
    // Odd half periods put only one edge in twenty on the sampling clock edge
    // About 29, 22 and 26 MHz: doubler input under 125 MHz
    // Doubled or divided by five, detector input stays in range
    always #17 pri_out = on_in[0] ? ~pri_out : 1'b0;
    always #23 sec_out = on_in[1] ? ~sec_out : 1'b0;
    always #19 crystal_input_out = on_in[2] ? ~crystal_input_out : 1'b0;
endmodule

// ==== test/rsh_switchover_props.sv ====
// Purpose: port-level checks of selection, calibration and divider
// Assumes: frequency pins change only well away from register writes
// Notes: mode field shadowed from observed writes
`timescale 1ns/1ps
module rsh_switchover_props
    import rsh_pkg::*;
#(
    parameter int DIV_W = 20
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic force_secondary_pin_in,
    input wire logic [3:0] freq_sel_a_in,
    input wire logic [5:0] freq_sel_y_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [DIV_W-1:0] fb_div_in,
    input wire logic pri_prescale_in,
    input wire logic pri_double_in,
    input wire logic [1:0] ref_select_out,
    input wire logic holdover_out,
    input wire logic [2:0] present_out,
    input wire logic cal_busy_out,
    input wire logic drivers_static_out,
    input wire logic [DIV_W-1:0] fb_div_out,
    input wire logic low_bw_filter_out,
    input wire logic [1:0] pri_path_out
);
    logic [1:0] mode_r;
    logic serial;
    // Shadow of the mode field; refused writes must not move it
    assign serial = (freq_sel_a_in == 4'h0) || (freq_sel_y_in == 6'h00);
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            mode_r <= 2'h0;
        end else if (reg_wr_in && serial && reg_addr_in == 8'h29) begin
            mode_r <= reg_wdata_in[7:6];
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    a_hold_is_crystal_input: assert property (
        holdover_out == (ref_select_out == RSH_SEL_CRYSTAL_INPUT))
        else $error("holdover flag disagrees with selection");
    a_pri_present: assert property (
        ref_select_out == RSH_SEL_PRI |-> present_out[0])
        else $error("absent primary selected");
    a_sec_present: assert property (
        ref_select_out == RSH_SEL_SEC |-> present_out[1])
        else $error("absent secondary selected");
    a_revert_pri: assert property (
        (mode_r == RSH_MODE_REVERT && present_out[0] && !force_secondary_pin_in)
        [*4] |-> ref_select_out == RSH_SEL_PRI)
        else $error("revertive mode left present primary");
    a_hold_entry: assert property (
        (!mode_r[1] && present_out == 3'b100) [*4] |-> holdover_out)
        else $error("no holdover with only crystal present");
    a_manual_nohold: assert property (
        mode_r[1] [*3] |-> !holdover_out)
        else $error("holdover in manual mode");
    a_manual_sec: assert property (
        (mode_r == RSH_MODE_MAN_SEC && present_out[1]) [*4]
        |-> ref_select_out == RSH_SEL_SEC)
        else $error("manual secondary not selected");
    a_cal_static: assert property (
        cal_busy_out |-> drivers_static_out)
        else $error("drivers toggling during calibration");
    a_boot_cal: assert property (
        $fell(sys_rst_in) |-> ##[1:4] cal_busy_out)
        else $error("no calibration after reset");
    a_cal_request: assert property (
        reg_wr_in && serial && reg_addr_in == 8'h0E && reg_wdata_in[7]
        && reg_wdata_in[2] |-> ##[1:8] cal_busy_out)
        else $error("calibrate request not started");
    a_div_clamp: assert property (
        !$past(sys_rst_in) |-> fb_div_out ==
        ($past(fb_div_in) < 32 ? 32 : $past(fb_div_in)))
        else $error("feedback divider not clamped");
    a_filter_bw: assert property (
        $stable(fb_div_out) |-> low_bw_filter_out == (fb_div_out >= 16384))
        else $error("loop filter choice wrong");
    a_path_cfg: assert property (
        !$past(sys_rst_in) |->
        pri_path_out == $past({pri_prescale_in, pri_double_in}))
        else $error("primary path setting wrong");
    // Main scenarios reached
    c_hold: cover property (holdover_out);
    c_nonrev_sec: cover property (
        mode_r == RSH_MODE_NONREV && ref_select_out == RSH_SEL_SEC);
    c_cal_done: cover property ($fell(cal_busy_out));
endmodule
bind rsh_switchover rsh_switchover_props #(.DIV_W(DIV_W)) i_props (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .force_secondary_pin_in(force_secondary_pin_in),
    .freq_sel_a_in(freq_sel_a_in), .freq_sel_y_in(freq_sel_y_in),
    .reg_wr_in(reg_wr_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .fb_div_in(fb_div_in),
    .pri_prescale_in(pri_prescale_in), .pri_double_in(pri_double_in),
    .ref_select_out(ref_select_out), .holdover_out(holdover_out),
    .present_out(present_out), .cal_busy_out(cal_busy_out),
    .drivers_static_out(drivers_static_out), .fb_div_out(fb_div_out),
    .low_bw_filter_out(low_bw_filter_out), .pri_path_out(pri_path_out));

// ==== test/testbench.sv ====
// Purpose: directed register and source sequences for the selector
// Assumes: short detector window and settle counts
// Notes: inputs move 1 ns after the rising edge
`timescale 1ns/1ps
module testbench
    import rsh_pkg::*;
;
    logic clk_in = 1'b0;
    logic rst = 1'b1;
    logic frc = 1'b0;
    logic wr = 1'b0;
    logic pp = 1'b0, pd = 1'b0, sp = 1'b0, sd = 1'b0;
    logic [3:0] fa = 4'h0;
    logic [5:0] fy = 6'h00;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic [19:0] fb_div = 20'h0_0040, fb_out;
    logic [19:0] dv [6] = '{20'h0_0000, 20'h0_001F, 20'h0_0020,
                            20'h0_3FFF, 20'h0_4000, 20'hF_FFFF};
    logic [2:0] src_on = 3'h7, present;
    logic [1:0] sel, pri_path, sec_path;
    logic [6:0] band;
    logic hold, busy, stat, low_bw, pri_c, sec_c, crystal_input_c;
    int fails = 0;
    int total_checks = 0;
    always #10 clk_in = ~clk_in;
    rsh_ref_model i_src (.on_in(src_on), .pri_out(pri_c),
        .sec_out(sec_c), .crystal_input_out(crystal_input_c));
    // Small window and settle keep the run short
    rsh_switchover #(.DET_WINDOW(8), .CAL_SETTLE(2)) i_dut (
        .clk_in(clk_in), .sys_rst_in(rst),
        .primary_reference_input_in(pri_c),
        .secondary_reference_input_in(sec_c), .crystal_input_in(crystal_input_c),
        .force_secondary_pin_in(frc), .freq_sel_a_in(fa),
        .freq_sel_y_in(fy), .reg_wr_in(wr), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .fb_div_in(fb_div), .pri_prescale_in(pp),
        .pri_double_in(pd), .sec_prescale_in(sp), .sec_double_in(sd),
        .vco_above_in(1'b0), .reg_rdata_out(rdata), .ref_select_out(sel),
        .holdover_out(hold), .present_out(present), .vco_band_out(band),
        .cal_busy_out(busy), .drivers_static_out(stat),
        .fb_div_out(fb_out), .low_bw_filter_out(low_bw),
        .pri_path_out(pri_path), .sec_path_out(sec_path));
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [19:0] seen,
                         input logic [19:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    // Trailing idle cycle so back-to-back calls never re-raise in one step
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        step(1);
        wr = 1'b0;
        step(1);
    endtask
    task automatic reg_chk(input logic [7:0] a, input logic [7:0] e);
        addr = a;
        step(2);
        check("reg_rdata_out", rdata, e);
    endtask
    task automatic wait_sel(input logic [1:0] e);
        int n;
        n = 0;
        while (sel !== e && n < 80) begin
            step(1);
            n++;
        end
        check("ref_select_out", sel, e);
        if (sel !== e) finish_test();
    endtask
    task automatic go(input logic [2:0] on, input logic [1:0] e);
        src_on = on;
        wait_sel(e);
    endtask
    task automatic wait_busy(input logic lvl, input int lim);
        int n;
        n = 0;
        while (busy !== lvl && n < lim) begin
            step(1);
            n++;
        end
        check("cal_busy_out", busy, lvl);
        if (busy !== lvl) finish_test();
    endtask
    initial begin
        step(5);
        rst = 1'b0;
        wait_busy(1'b1, 10);
        check("drivers_static_out", stat, 1'b1);
        wait_busy(1'b0, 400);
        check("vco_band_out", band, 7'h7F);
        check("drivers_static_out", stat, 1'b0);
        reg_chk(8'h29, 8'h00);
        wait_sel(RSH_SEL_PRI);
        // Revertive: lose sources one by one, then bring back secondary and primary
        go(3'b110, RSH_SEL_SEC);
        go(3'b100, RSH_SEL_CRYSTAL_INPUT);
        go(3'b000, RSH_SEL_NONE);
        go(3'b010, RSH_SEL_SEC);
        go(3'b011, RSH_SEL_PRI);
        // Nonrevertive keeps secondary after primary returns
        reg_wr(8'h29, 8'h40);
        go(3'b110, RSH_SEL_SEC);
        src_on = 3'b111;
        step(30);
        check("ref_select_out", sel, RSH_SEL_SEC);
        go(3'b101, RSH_SEL_PRI);
        go(3'b100, RSH_SEL_CRYSTAL_INPUT);
        // Primary back first, so a quicker secondary cannot win the race
        go(3'b101, RSH_SEL_PRI);
        src_on = 3'b111;
        // Force pin against automatic and manual primary
        reg_wr(8'h29, 8'h00);
        frc = 1'b1;
        wait_sel(RSH_SEL_SEC);
        go(3'b101, RSH_SEL_PRI);
        go(3'b111, RSH_SEL_SEC);
        reg_wr(8'h29, 8'h80);
        step(30);
        check("ref_select_out", sel, RSH_SEL_SEC);
        frc = 1'b0;
        wait_sel(RSH_SEL_PRI);
        go(3'b110, RSH_SEL_NONE);
        src_on = 3'b100;
        step(30);
        check("holdover_out", hold, 1'b0);
        reg_wr(8'h29, 8'hC0);
        step(30);
        check("holdover_out", hold, 1'b0);
        go(3'b111, RSH_SEL_SEC);
        // Write with pins out of serial pattern is dropped
        fa = 4'h1;
        fy = 6'h01;
        step(4);
        reg_wr(8'h29, 8'h40);
        fa = 4'h0;
        fy = 6'h00;
        step(4);
        reg_chk(8'h29, 8'hC0);
        check("present_out", present, 3'h7);
        // Calibrate bit alone is ignored, with enable it launches
        reg_wr(8'h0E, 8'h80);
        step(6);
        check("cal_busy_out", busy, 1'b0);
        reg_wr(8'h0E, 8'h84);
        wait_busy(1'b1, 10);
        check("drivers_static_out", stat, 1'b1);
        wait_busy(1'b0, 400);
        reg_chk(8'h0E, 8'h04);
        // Band override, mid and top band
        reg_wr(8'h10, 8'h54);
        reg_wr(8'h0E, 8'h05);
        step(2);
        check("vco_band_out", band, 7'h2A);
        reg_wr(8'h10, 8'hFE);
        step(2);
        check("vco_band_out", band, 7'h7F);
        reg_chk(8'h10, 8'hFE);
        // Divider clamp and filter threshold boundaries
        foreach (dv[i]) begin
            fb_div = dv[i];
            step(3);
            check("fb_div_out", fb_out,
                  dv[i] < 32 ? 20'h0_0020 : dv[i]);
            check("low_bw_filter_out", low_bw, dv[i] >= 20'h0_4000);
        end
        // Every prescaler and doubler setting on both paths
        for (int i = 0; i < 16; i++) begin
            {pp, pd, sp, sd} = i[3:0];
            step(2);
            check("pri_path_out", pri_path, {pp, pd});
            check("sec_path_out", sec_path, {sp, sd});
        end
        // Reset in mid-run restores revertive mode and recalibrates
        rst = 1'b1;
        step(5);
        rst = 1'b0;
        wait_busy(1'b1, 10);
        reg_chk(8'h29, 8'h00);
        wait_busy(1'b0, 400);
        finish_test();
    end
endmodule
